// *** logic/bsmp_map.svh ***
`ifndef BSMP_MAP_SVH
`define BSMP_MAP_SVH

// Register byte addresses
`define BSMP_ADDR_PIN_SEL1      32'h01c40004
`define BSMP_ADDR_BOOT_CFG      32'h01c40014
`define BSMP_ADDR_CORE_PRIO     32'h01c4003c
`define BSMP_ADDR_PERIPH_PRIO   32'h01c40040

// Widths and counts
`define BSMP_PRIO_W             3
`define BSMP_NUM_MASTERS        9
`define BSMP_BYTE_W             8

// Priority field positions
`define BSMP_CORE_CFG_LSB       8
`define BSMP_PCI_LSB            24
`define BSMP_HOST_LSB           20
`define BSMP_SERIAL_LSB         16
`define BSMP_ETH_LSB            0

// Priority reset values
`define BSMP_CORE_CFG_RST       3'h1
`define BSMP_PERIPH_RST         3'h4

// Boot capture field positions
`define BSMP_BOOT_PLL_LSB       0
`define BSMP_BOOT_ENDIAN_BIT    4
`define BSMP_BOOT_FAST_BIT      8
`define BSMP_BOOT_PCI_BIT       12

// Pin function select field position
`define BSMP_PINSEL_PCI_BIT     0

// Arbiter master indices
`define BSMP_M_TC0              0
`define BSMP_M_TC1              1
`define BSMP_M_TC2              2
`define BSMP_M_CORE_DMA         3
`define BSMP_M_CORE_CFG         4
`define BSMP_M_ETH              5
`define BSMP_M_SERIAL           6
`define BSMP_M_HOST             7
`define BSMP_M_PCI              8

`endif

// *** logic/bsmp_pkg.sv ***
`include "bsmp_map.svh"

package bsmp_pkg;

    typedef logic [`BSMP_PRIO_W-1:0] bsmp_level_t;

    typedef struct packed {
        bsmp_level_t core_cfg;
        bsmp_level_t pci;
        bsmp_level_t host_port;
        bsmp_level_t serial_link;
        bsmp_level_t ethernet;
    } bsmp_prio_t;

    typedef struct packed {
        logic        done;
        logic        fast_boot;
        bsmp_level_t pll_mult;
        logic        little_endian;
        logic        pci_use;
    } bsmp_boot_t;

    typedef struct packed {
        bsmp_prio_t                   prio;
        logic [31:0]                  rdata;
        logic [`BSMP_NUM_MASTERS-1:0] grant;
    } bsmp_state_t;

endpackage

// *** logic/bsmp_strap_latch.sv ***
`timescale 1ns/1ps
`include "bsmp_map.svh"

module bsmp_strap_latch (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   pce,
    input  wire logic                   fast_boot_strap,
    input  wire logic [`BSMP_PRIO_W-1:0] pll_multiplier_strap,
    input  wire logic                   byte_order_strap,
    input  wire logic                   pci_use_strap,
    output bsmp_pkg::bsmp_boot_t        boot
);

    bsmp_pkg::bsmp_boot_t s_q;
    bsmp_pkg::bsmp_boot_t s_d;

    // First enabled edge after release takes the straps, then holds
    always_comb
    begin
        s_d = s_q;
        if (!s_q.done)
        begin
            s_d.done          = 1'b1;                  // RULE_17
            s_d.fast_boot     = fast_boot_strap;
            s_d.pll_mult      = pll_multiplier_strap;  // RULE_02
            s_d.little_endian = byte_order_strap;      // RULE_03
            s_d.pci_use       = pci_use_strap;         // RULE_07
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else if (pce)
            s_q <= s_d;
    end

    assign boot = s_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_capture_at_release: assert property (!s_q.done && pce |=> s_q.done // RULE_02
                                           && s_q.pll_mult == $past(pll_multiplier_strap)
                                           && s_q.little_endian == $past(byte_order_strap))
        else $error("Straps not captured on first edge");
    a_straps_held: assert property (s_q.done |=> $stable(s_q)) // RULE_17
        else $error("Captured straps changed after capture");

endmodule

// *** logic/bsmp_prio_arb.sv ***
`timescale 1ns/1ps

module bsmp_prio_arb #(
    parameter int N = 9,
    parameter int W = 3
) (
    input  wire logic [N-1:0]   req,
    input  wire logic [N*W-1:0] prio,
    output logic [N-1:0]        grant
);

    if (N < 1 || W < 1)
    begin : g_bad
        $error("Arbiter needs at least one master and one level bit");
    end

    // Lowest level wins, ties go to the lower index
    always_comb
    begin
        logic         found;
        logic [W-1:0] best;
        found = 1'b0;
        best  = '0;
        grant = '0;
        for (int i = 0; i < N; i++)
        begin
            if (req[i] && (!found || prio[i*W +: W] < best)) // RULE_09
            begin
                found = 1'b1;
                best  = prio[i*W +: W];
                grant = '0;
                grant[i] = 1'b1;
            end
        end
    end

endmodule

// *** logic/bsmp_top.sv ***
// Overview of operation
// (RULE_01) Multiplier straps used only under fast boot
// (RULE_02) Multiplier strap captured at release, read-only
// (RULE_03) Byte order strap one selects little endian
// (RULE_04) Captured byte order unaffected by writes
// (RULE_05) PCI strap one: PCI pins, pulls off
// (RULE_06) PCI strap zero: other pins, pulls on
// (RULE_07) PCI strap copied to two read-only fields
// (RULE_08) System holds PCI strap level during operation
// (RULE_09) Lower priority value wins fabric arbitration
// (RULE_10) Three-bit levels, zero highest, seven lowest
// (RULE_11) Core config port priority bits 10:8
// (RULE_12) PCI, host, serial link fields reset four
// (RULE_13) Ethernet priority bits 2:0 reset four
// (RULE_14) Reserved priority bits read zero
// (RULE_15) Transfer and core DMA priorities come externally
// (RULE_16) Software may tune priority levels
// (RULE_17) Straps sampled once, held until reset
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "bsmp_map.svh"

module bsmp_top #(
    parameter int NUM_MASTERS = `BSMP_NUM_MASTERS,
    parameter int PRIO_W      = `BSMP_PRIO_W
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   pce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   fast_boot_strap,
    input  wire logic [PRIO_W-1:0]      pll_multiplier_strap,
    input  wire logic                   byte_order_strap,
    input  wire logic                   pci_use_strap,
    output logic [PRIO_W-1:0]           pll_mult_sel,
    output logic                        pll_mult_valid,
    output logic                        little_endian,
    output logic                        pci_pin_function,
    output logic                        pci_pull_enable,
    input  wire logic [PRIO_W-1:0]      transfer_ctrl0_priority,
    input  wire logic [PRIO_W-1:0]      transfer_ctrl1_priority,
    input  wire logic [PRIO_W-1:0]      transfer_ctrl2_priority,
    input  wire logic [PRIO_W-1:0]      core_dma_port_priority,
    input  wire logic [NUM_MASTERS-1:0] master_req,
    output logic [NUM_MASTERS-1:0]      master_grant,
    output bsmp_pkg::bsmp_prio_t        master_prio
);

    if (NUM_MASTERS != `BSMP_NUM_MASTERS || PRIO_W != `BSMP_PRIO_W)
    begin : g_bad_params
        $error("Master count and level width are fixed by the register map");
    end

    localparam bsmp_pkg::bsmp_state_t S_RST = '{
        prio: '{
            core_cfg:    `BSMP_CORE_CFG_RST,
            pci:         `BSMP_PERIPH_RST,
            host_port:   `BSMP_PERIPH_RST,
            serial_link: `BSMP_PERIPH_RST,
            ethernet:    `BSMP_PERIPH_RST
        },
        rdata: '0,
        grant: '0
    };

    bsmp_pkg::bsmp_state_t      s_q;
    bsmp_pkg::bsmp_state_t      s_d;
    bsmp_pkg::bsmp_boot_t       boot;
    logic [NUM_MASTERS-1:0]     arb_grant;
    logic [NUM_MASTERS*PRIO_W-1:0] arb_prio;
    logic [31:0]                rd_word;
    logic                       addr_hit;
    logic                       setup_ph;
    logic                       access_ph;
    logic                       wr_core;
    logic                       wr_periph;

    // Strap capture
    bsmp_strap_latch u_straps (
        .pclk                 (pclk),
        .presetn              (presetn),
        .pce                  (pce),
        .fast_boot_strap      (fast_boot_strap),
        .pll_multiplier_strap (pll_multiplier_strap),
        .byte_order_strap     (byte_order_strap),
        .pci_use_strap        (pci_use_strap),
        .boot                 (boot)
    );

    // Fabric arbitration over all masters
    always_comb
    begin
        arb_prio = '0;
        arb_prio[`BSMP_M_TC0*PRIO_W +: PRIO_W]      = transfer_ctrl0_priority; // RULE_15
        arb_prio[`BSMP_M_TC1*PRIO_W +: PRIO_W]      = transfer_ctrl1_priority; // RULE_15
        arb_prio[`BSMP_M_TC2*PRIO_W +: PRIO_W]      = transfer_ctrl2_priority; // RULE_15
        arb_prio[`BSMP_M_CORE_DMA*PRIO_W +: PRIO_W] = core_dma_port_priority;  // RULE_15
        arb_prio[`BSMP_M_CORE_CFG*PRIO_W +: PRIO_W] = s_q.prio.core_cfg;
        arb_prio[`BSMP_M_ETH*PRIO_W +: PRIO_W]      = s_q.prio.ethernet;
        arb_prio[`BSMP_M_SERIAL*PRIO_W +: PRIO_W]   = s_q.prio.serial_link;
        arb_prio[`BSMP_M_HOST*PRIO_W +: PRIO_W]     = s_q.prio.host_port;
        arb_prio[`BSMP_M_PCI*PRIO_W +: PRIO_W]      = s_q.prio.pci;
    end

    bsmp_prio_arb #(
        .N (NUM_MASTERS),
        .W (PRIO_W)
    ) u_arb (
        .req   (master_req),
        .prio  (arb_prio),
        .grant (arb_grant)
    );

    // Bus phase decode
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;

    always_comb
    begin
        addr_hit = 1'b1;
        rd_word  = '0;
        case (paddr)
            `BSMP_ADDR_CORE_PRIO:
            begin
                rd_word[`BSMP_CORE_CFG_LSB +: PRIO_W] = s_q.prio.core_cfg; // RULE_14
            end
            `BSMP_ADDR_PERIPH_PRIO:
            begin
                rd_word[`BSMP_PCI_LSB +: PRIO_W]    = s_q.prio.pci;        // RULE_14
                rd_word[`BSMP_HOST_LSB +: PRIO_W]   = s_q.prio.host_port;
                rd_word[`BSMP_SERIAL_LSB +: PRIO_W] = s_q.prio.serial_link;
                rd_word[`BSMP_ETH_LSB +: PRIO_W]    = s_q.prio.ethernet;
            end
            `BSMP_ADDR_BOOT_CFG:
            begin
                rd_word[`BSMP_BOOT_PLL_LSB +: PRIO_W] = boot.pll_mult;      // RULE_02
                rd_word[`BSMP_BOOT_ENDIAN_BIT]        = boot.little_endian; // RULE_04
                rd_word[`BSMP_BOOT_FAST_BIT]          = boot.fast_boot;
                rd_word[`BSMP_BOOT_PCI_BIT]           = boot.pci_use;       // RULE_07
            end
            `BSMP_ADDR_PIN_SEL1:
            begin
                rd_word[`BSMP_PINSEL_PCI_BIT] = boot.pci_use; // RULE_07
            end
            default:
            begin
                addr_hit = 1'b0;
            end
        endcase
    end

    assign wr_core   = access_ph && pce && pwrite && paddr == `BSMP_ADDR_CORE_PRIO;
    assign wr_periph = access_ph && pce && pwrite && paddr == `BSMP_ADDR_PERIPH_PRIO;

    // Next state: read capture, priority writes, registered grant
    always_comb
    begin
        s_d = s_q;
        if (setup_ph)
        begin
            s_d.rdata = rd_word;
        end
        if (wr_core && pstrb[`BSMP_CORE_CFG_LSB / `BSMP_BYTE_W])
        begin
            s_d.prio.core_cfg = pwdata[`BSMP_CORE_CFG_LSB +: PRIO_W]; // RULE_11
        end
        if (wr_periph && pstrb[`BSMP_PCI_LSB / `BSMP_BYTE_W])
        begin
            s_d.prio.pci = pwdata[`BSMP_PCI_LSB +: PRIO_W]; // RULE_12
        end
        if (wr_periph && pstrb[`BSMP_HOST_LSB / `BSMP_BYTE_W])
        begin
            s_d.prio.host_port = pwdata[`BSMP_HOST_LSB +: PRIO_W]; // RULE_12
        end
        if (wr_periph && pstrb[`BSMP_SERIAL_LSB / `BSMP_BYTE_W])
        begin
            s_d.prio.serial_link = pwdata[`BSMP_SERIAL_LSB +: PRIO_W]; // RULE_12
        end
        if (wr_periph && pstrb[`BSMP_ETH_LSB / `BSMP_BYTE_W])
        begin
            s_d.prio.ethernet = pwdata[`BSMP_ETH_LSB +: PRIO_W]; // RULE_13
        end
        s_d.grant = arb_grant; // RULE_09
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= S_RST;
        else if (pce)
            s_q <= s_d;
    end

    // Bus answers in the first access cycle unless frozen
    assign pready  = access_ph && pce;
    assign pslverr = access_ph && pce && !addr_hit;
    assign prdata  = s_q.rdata;

    assign master_grant = s_q.grant;
    assign master_prio  = s_q.prio; // RULE_10

    // Boot-time controls
    assign pll_mult_valid   = boot.done && boot.fast_boot;                        // RULE_01
    assign pll_mult_sel     = pll_mult_valid ? boot.pll_mult : '0;                // RULE_01
    assign little_endian    = boot.little_endian;                                 // RULE_03
    assign pci_pin_function = boot.pci_use;                                       // RULE_05
    assign pci_pull_enable  = !boot.pci_use;                                      // RULE_06

    // Checking helpers
    logic [PRIO_W-1:0] granted_level;
    logic              better_waiting;

    always_comb
    begin
        granted_level  = '0;
        better_waiting = 1'b0;
        for (int i = 0; i < NUM_MASTERS; i++)
        begin
            if (arb_grant[i])
                granted_level = arb_prio[i*PRIO_W +: PRIO_W];
        end
        for (int i = 0; i < NUM_MASTERS; i++)
        begin
            if (master_req[i] && arb_prio[i*PRIO_W +: PRIO_W] < granted_level)
                better_waiting = 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_core_write_lands: assert property (wr_core && pstrb[1] |=> s_q.prio.core_cfg == $past(pwdata[10:8])) // RULE_11
        else $error("Core config port priority write lost");
    a_pci_write_lands: assert property (wr_periph && pstrb[3] |=> s_q.prio.pci == $past(pwdata[26:24])) // RULE_12
        else $error("PCI priority write lost");
    a_eth_write_lands: assert property (wr_periph && pstrb[0] |=> s_q.prio.ethernet == $past(pwdata[2:0])) // RULE_13
        else $error("Ethernet priority write lost");
    a_reserved_read_zero: assert property (setup_ph && pce && paddr == `BSMP_ADDR_PERIPH_PRIO // RULE_14
                                           |=> (prdata & 32'hf888fff8) == 32'h00000000)
        else $error("Reserved priority bits read nonzero");
    a_core_rsv_zero: assert property (setup_ph && pce && paddr == `BSMP_ADDR_CORE_PRIO // RULE_14
                                      |=> (prdata & 32'hfffff8ff) == 32'h00000000)
        else $error("Reserved core priority bits read nonzero");
    a_boot_read_only: assert property (access_ph && pwrite && paddr == `BSMP_ADDR_BOOT_CFG && boot.done // RULE_04
                                       |=> $stable(little_endian) && $stable(pci_pin_function))
        else $error("Boot capture changed by a write");
    a_pll_gated: assert property (!fast_boot_strap && pce && !boot.done |=> ##[0:2] pll_mult_sel == 3'h0) // RULE_01
        else $error("Multiplier select used without fast boot");
    a_pull_follows_pci: assert property (boot.done |-> pci_pull_enable != pci_pin_function) // RULE_05
        else $error("Pull enable not opposite of PCI function");
    a_lowest_wins: assert property (arb_grant != '0 |-> !better_waiting) // RULE_09
        else $error("Grant went to a worse priority level");
    a_grant_registered: assert property (master_req != '0 && pce |=> $onehot(master_grant) // RULE_09
                                         && (master_grant & ~$past(master_req)) == '0)
        else $error("Grant missing or not requested");
    a_reset_levels: assert property ($rose(presetn) |-> s_q.prio.core_cfg == 3'h1 && s_q.prio.pci == 3'h4) // RULE_10
        else $error("Priority reset levels wrong");

    // Register writes
    a_host_write_lands: assert property (wr_periph && pstrb[2] // RULE_12
        |=> s_q.prio.host_port == $past(pwdata[22:20]))
        else $error("Host port priority write lost");

    a_serial_write_lands: assert property (wr_periph && pstrb[2] // RULE_12
        |=> s_q.prio.serial_link == $past(pwdata[18:16]))
        else $error("Serial link priority write lost");

    a_core_lane_guard: assert property (wr_core && !pstrb[1] // RULE_11
        |=> $stable(s_q.prio.core_cfg))
        else $error("Core priority changed without its lane");

    a_eth_lane_guard: assert property (wr_periph && !pstrb[0] // RULE_13
        |=> $stable(s_q.prio.ethernet))
        else $error("Ethernet priority changed without its lane");

    a_prio_only_by_write: assert property (!wr_core && !wr_periph // RULE_10
        |=> $stable(s_q.prio))
        else $error("Priority level changed without a write");

    // Register reads
    a_boot_read_fields: assert property (setup_ph && pce && paddr == `BSMP_ADDR_BOOT_CFG // RULE_02
        |=> prdata[2:0] == $past(boot.pll_mult) && prdata[4] == $past(boot.little_endian)
            && prdata[8] == $past(boot.fast_boot) && prdata[12] == $past(boot.pci_use))
        else $error("Boot capture read back wrong");

    a_pinsel_read: assert property (setup_ph && pce && paddr == `BSMP_ADDR_PIN_SEL1 // RULE_07
        |=> prdata == {31'h0, $past(boot.pci_use)})
        else $error("Pin function select read back wrong");

    a_boot_cfg_no_error: assert property (access_ph && pce && paddr == `BSMP_ADDR_BOOT_CFG // RULE_04
        |-> !pslverr)
        else $error("Boot capture access flagged as error");

    // Boot-time outputs
    a_pll_sel_valid: assert property (pll_mult_valid |-> pll_mult_sel == boot.pll_mult) // RULE_01
        else $error("Multiplier select differs from capture");

    a_pll_ignored: assert property (!boot.fast_boot |-> pll_mult_sel == 3'h0 && !pll_mult_valid) // RULE_01
        else $error("Multiplier select live without fast boot");

    a_pci_pins_used: assert property (boot.done && boot.pci_use // RULE_05
        |-> pci_pin_function && !pci_pull_enable)
        else $error("PCI use without PCI pins and pulls off");

    a_pci_pins_unused: assert property (boot.done && !boot.pci_use // RULE_06
        |-> !pci_pin_function && pci_pull_enable)
        else $error("PCI unused without other pins and pulls on");

    a_endian_select: assert property (boot.done |-> little_endian == boot.little_endian) // RULE_03
        else $error("Byte order output differs from capture");

    // Arbitration
    a_grant_onehot: assert property ($onehot0(master_grant)) // RULE_09
        else $error("More than one master granted");

    a_dma_level_loses: assert property (master_req[`BSMP_M_CORE_DMA] && master_req[`BSMP_M_TC0] // RULE_15
        && core_dma_port_priority > transfer_ctrl0_priority && pce
        |=> !master_grant[`BSMP_M_CORE_DMA])
        else $error("Core DMA won over a better transfer level");

    a_eth_beats_pci: assert property (master_req[`BSMP_M_ETH] && master_req[`BSMP_M_PCI] // RULE_13
        && s_q.prio.ethernet <= s_q.prio.pci && pce
        |=> !master_grant[`BSMP_M_PCI])
        else $error("PCI won over an equal or better ethernet level");

    c_core_write: cover property (wr_core && pstrb[1]);
    c_fast_boot: cover property (pll_mult_valid);
    c_boot_read: cover property (setup_ph && !pwrite && paddr == `BSMP_ADDR_BOOT_CFG ##1 pready);
    c_contention: cover property ($countones(master_req) > 1 && pce);
    c_unmapped: cover property (pslverr);

endmodule

// *** testbench/bsmp_master_model.sv ***
`timescale 1ns/1ps

// Masters in the fabric: a request stands until it is granted
module bsmp_master_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [8:0] want,
    input  wire logic [8:0] grant,
    output logic [8:0]      req,
    output logic [2:0]      tc0_level,
    output logic [2:0]      tc1_level,
    output logic [2:0]      tc2_level,
    output logic [2:0]      dma_level
);
    logic [8:0] want_q;

    // Levels are tied constants: transfer controllers at zero, core DMA at seven
    assign tc0_level = 3'h0;
    assign tc1_level = 3'h0;
    assign tc2_level = 3'h0;
    assign dma_level = 3'h7;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req    <= 9'h000;
            want_q <= 9'h000;
        end
        else
        begin
            want_q <= want;
            req    <= (req & ~grant) | (want & ~want_q);
        end
    end
endmodule

// *** testbench/boot_straps_and_master_priority_tb.sv ***
`timescale 1ns/1ps
`include "bsmp_map.svh"

module boot_straps_and_master_priority_tb;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [31:0]          paddr = 32'h0;
    logic [31:0]          pwdata = 32'h0;
    logic [3:0]           pstrb = 4'hf;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 fast_s = 1'b0;
    logic [2:0]           pll_s = 3'h0;
    logic                 endian_s = 1'b0;
    logic                 pci_s = 1'b0;
    logic [2:0]           pll_mult_sel;
    logic                 pll_mult_valid;
    logic                 little_endian;
    logic                 pci_pin_function;
    logic                 pci_pull_enable;
    logic [2:0]           lv0, lv1, lv2, lv3;
    logic [8:0]           want = 9'h0;
    logic [8:0]           master_req;
    logic [8:0]           master_grant;
    bsmp_pkg::bsmp_prio_t master_prio;
    int                   n_fail = 0;
    int                   checks_done = 0;

    always #20 pclk = ~pclk;

    bsmp_top DUT (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fast_boot_strap(fast_s), .pll_multiplier_strap(pll_s),
        .byte_order_strap(endian_s), .pci_use_strap(pci_s), .pll_mult_sel(pll_mult_sel),
        .pll_mult_valid(pll_mult_valid), .little_endian(little_endian),
        .pci_pin_function(pci_pin_function), .pci_pull_enable(pci_pull_enable),
        .transfer_ctrl0_priority(lv0), .transfer_ctrl1_priority(lv1), .transfer_ctrl2_priority(lv2),
        .core_dma_port_priority(lv3), .master_req(master_req), .master_grant(master_grant),
        .master_prio(master_prio));

    bsmp_master_model masters (.pclk(pclk), .presetn(presetn), .want(want), .grant(master_grant),
        .req(master_req), .tc0_level(lv0), .tc1_level(lv1), .tc2_level(lv2), .dma_level(lv3));

    task automatic print_verdict;
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 50)
        begin
            n_fail++;
            print_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_grant(input logic [8:0] prev, output logic [8:0] g);
        int k;
        g = 9'h0;
        for (k = 0; k < 20 && (g === 9'h0 || g === prev); k++)
        begin
            @(posedge pclk);
            g = master_grant;
        end
        if (g === 9'h0 || g === prev)
        begin
            n_fail++;
            print_verdict();
        end
    endtask

    task automatic do_reset(input logic f, input logic [2:0] p, input logic e, input logic c);
        @(posedge pclk);
        presetn <= 1'b0;
        fast_s <= f;
        pll_s <= p;
        endian_s <= e;
        pci_s <= c;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task automatic arb(input logic [8:0] w, input logic [8:0] first, input logic [8:0] second);
        logic [8:0] g;
        @(posedge pclk);
        want <= w;
        @(posedge pclk);
        want <= 9'h0;
        wait_grant(9'h0, g);
        check("first grant", {23'h0, g}, {23'h0, first});
        wait_grant(g, g);
        check("second grant", {23'h0, g}, {23'h0, second});
    endtask

    task automatic strap_outputs(input logic f, input logic [2:0] p, input logic e, input logic c);
        check("pll sel", {29'h0, pll_mult_sel}, {29'h0, f ? p : 3'h0});
        check("pll valid", {31'h0, pll_mult_valid}, {31'h0, f});
        check("endian", {31'h0, little_endian}, {31'h0, e});
        check("pin function", {31'h0, pci_pin_function}, {31'h0, c});
        check("pull enable", {31'h0, pci_pull_enable}, {31'h0, ~c});
    endtask

    logic [31:0] rd;
    logic        er;
    logic [3:0]  t;
    logic [31:0] boot_exp;

    initial
    begin
        for (int i = 0; i < 2; i++)
        begin
            t = (i == 0) ? 4'hd : 4'h6;
            do_reset(t[0], t[3:1], t[0], t[0]);
            boot_exp = {19'h0, t[0], 3'h0, t[0], 3'h0, t[0], 1'b0, t[3:1]};
            strap_outputs(t[0], t[3:1], t[0], t[0]);
            apb(1'b1, `BSMP_ADDR_BOOT_CFG, 32'hffffffff, 4'hf, rd, er);
            apb(1'b1, `BSMP_ADDR_PIN_SEL1, 32'hffffffff, 4'hf, rd, er);
            apb(1'b0, `BSMP_ADDR_BOOT_CFG, 32'h0, 4'hf, rd, er);
            check("boot capture", rd, boot_exp);
            apb(1'b0, `BSMP_ADDR_PIN_SEL1, 32'h0, 4'hf, rd, er);
            check("pin select", rd, {31'h0, t[0]});
            // Pci strap level stays put; the others move after capture
            @(posedge pclk);
            fast_s <= ~t[0];
            pll_s <= ~t[3:1];
            endian_s <= ~t[0];
            pci_s <= t[0];
            repeat (3) @(posedge pclk);
            strap_outputs(t[0], t[3:1], t[0], t[0]);
            apb(1'b0, `BSMP_ADDR_BOOT_CFG, 32'h0, 4'hf, rd, er);
            check("boot held", rd, boot_exp);
        end
        apb(1'b0, `BSMP_ADDR_CORE_PRIO, 32'h0, 4'hf, rd, er);
        check("core prio reset", rd, 32'h00000100);
        apb(1'b0, `BSMP_ADDR_PERIPH_PRIO, 32'h0, 4'hf, rd, er);
        check("periph prio reset", rd, 32'h04440004);
        apb(1'b1, `BSMP_ADDR_PERIPH_PRIO, 32'hffffffff, 4'h1, rd, er);
        apb(1'b0, `BSMP_ADDR_PERIPH_PRIO, 32'h0, 4'hf, rd, er);
        check("eth lane only", rd, 32'h04440007);
        apb(1'b1, `BSMP_ADDR_CORE_PRIO, 32'hffffffff, 4'hf, rd, er);
        apb(1'b0, `BSMP_ADDR_CORE_PRIO, 32'h0, 4'hf, rd, er);
        check("core reserved", rd, 32'h00000700);
        apb(1'b1, `BSMP_ADDR_PERIPH_PRIO, 32'hffffffff, 4'hf, rd, er);
        apb(1'b0, `BSMP_ADDR_PERIPH_PRIO, 32'h0, 4'hf, rd, er);
        check("periph reserved", rd, 32'h07770007);
        apb(1'b0, 32'h01c40044, 32'h0, 4'hf, rd, er);
        check("unmapped error", {31'h0, er}, 32'h1);
        arb(9'h009, 9'h001, 9'h008);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, `BSMP_ADDR_PERIPH_PRIO, {5'h0, 3'(7 - i), 21'h088000, 3'(i)}, 4'hf, rd, er);
            @(posedge pclk);
            check("eth level", {29'h0, master_prio.ethernet}, i);
            check("pci level", {29'h0, master_prio.pci}, 7 - i);
            arb(9'h120, (i < 4) ? 9'h020 : 9'h100, (i < 4) ? 9'h100 : 9'h020);
        end
        print_verdict();
    end
endmodule
